/* rmc_cfg.svh */
// Constants for the retry miss cache controller: offsets, field positions, reset values and timing.
// Operation
// R1: 32 KB direct-mapped write-through, one-word lines.
// R2: Logical-address indexed; three-clock shortest access.
// R3: Miss runs cached read, then refilling retry.
// R4: Retry request ready by processor state S4.
// R5: Miss costs eight half-cycles, 120 ns.
// R6: Index A2-A14; compare upper, size, code, valid.
// R7: Tag reset clears every entry within 55 ns.
// R8: Valid compare tied high; cleared never hits.
// R9: Hit blocked: CPU space, I/O, disabled, no strobe.
// R10: Data array shares index, drives via gated hit.
// R11: Enable, disable, flush decoded in CPU space.
// R12: Enable/disable set cache-on; enable clears tags.
// R13: Flush clears tags; 50 ns strobe limit.
// R14: Two cascaded samples of the tag match.
// R15: Acknowledge at S2, error plus halt at S4.
// R16: Miss flag gated into error and halt.
// R17: Third latch gates acknowledge and error outputs.
// R18: Suppress spans miss strobe end to refill end.
// R19: No answers in refill, writes, or disabled; code still acknowledges CPU-space commands while disabled.
// R20: Arrays written on writes and every refill.
// R21: Refill strobe: strobe and suppress, two clocks.
// R22: Refill ends when processor takes memory data.
// R23: Cache starts disabled after system reset.
`ifndef RMC_CFG_SVH
`define RMC_CFG_SVH
`define RMC_CLK_MHZ 125
`define RMC_PCLK_NS 30
`define RMC_ACK_NS 30
`define RMC_BUS_ERROR_NS 60
`define RMC_MISS_PENALTY_NS 120
`define RMC_TAG_CLR_NS 55
`define RMC_REFILL_NS 60
`define RMC_CYC_FLOOR(ns) (((ns) * `RMC_CLK_MHZ) / 1000)
`define RMC_CYC_CEIL(ns) (((ns) * `RMC_CLK_MHZ + 999) / 1000)
`define RMC_OFF_CTRL 32'h0000_0000
`define RMC_OFF_STATUS 32'h0000_0004
`define RMC_OFF_HITS 32'h0000_0008
`define RMC_OFF_MISSES 32'h0000_000c
`define RMC_CTRL_ON_BIT 0
`define RMC_CTRL_FLUSH_BIT 1
`define RMC_STAT_ON_BIT 0
`define RMC_STAT_SUPP_BIT 1
`define RMC_STAT_CLR_BIT 2
`define RMC_CMD_ENABLE 2'h1
`define RMC_CMD_DISABLE 2'h2
`define RMC_CMD_FLUSH 2'h3
`define RMC_CPU_SPACE_FC 3'h7
`define RMC_CACHE_ON_RST 1'b0
`endif

/* rmc_pkg.sv */
// Types shared by the retry miss cache controller.
package rmc_pkg;
  // Processor bus as seen at the controller's pins.
  typedef struct packed {
    logic addr_strobe_n;
    logic write;
    logic wr_strobe_n;
    logic [2:0] function_code;
    logic [1:0] transfer_size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rmc_cpu_bus_t;
  // Answers driven back towards the processor and buffers.
  typedef struct packed {
    logic cycle_ack;
    logic bus_error;
    logic halt;
    logic miss_flag;
    logic gated_hit;
    logic rdata_oe;
    logic [31:0] rdata;
  } rmc_cpu_resp_t;
  // Bus cycle sequencer states.
  typedef enum logic [2:0] {
    RMC_IDLE, RMC_LOOK, RMC_HOLD, RMC_WRITE, RMC_REFILL, RMC_CMD
  } rmc_state_t;
endpackage : rmc_pkg

/* rmc_cache_ctrl.sv */
// Retry miss cache controller with tag and data arrays and an AHB-Lite register slave.
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "rmc_cfg.svh"
module rmc_cache_ctrl #(
  parameter int IDX_W = 13,
  parameter logic [31:0] IO_BASE = 32'hff00_0000,
  parameter logic [31:0] IO_MASK = 32'hff00_0000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire rmc_pkg::rmc_cpu_bus_t cpu_bus,
  input wire logic sys_ack_n,
  input wire logic [31:0] sys_rdata,
  output rmc_pkg::rmc_cpu_resp_t cpu_resp,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import rmc_pkg::*;

  // Cycle counts derived from the documented times at the clk rate.
  localparam int ACK_CYC = `RMC_CYC_FLOOR(`RMC_ACK_NS);
  localparam int BUS_ERROR_CYC = `RMC_CYC_FLOOR(`RMC_BUS_ERROR_NS);
  localparam int CLR_CYC = `RMC_CYC_CEIL(`RMC_TAG_CLR_NS);
  localparam int REFILL_CYC = `RMC_CYC_FLOOR(`RMC_REFILL_NS);
  localparam int DEPTH = 1 << IDX_W;
  localparam int UP_W = 32 - IDX_W - 2;
  localparam int TAG_W = UP_W + 5;

  // Tag word kept per line: upper address, size and function code.
  logic [TAG_W-1:0] tag_mem [DEPTH];
  // Two valid bits per line; compared against a constant high pair.
  logic [1:0] valid_mem [DEPTH];
  // Data word per line.
  logic [31:0] data_mem [DEPTH];

  // Three-stage synchronisers for address strobe, write strobe and memory ack.
  logic [2:0] as_sync_reg, ws_sync_reg, sa_sync_reg;
  // Filtered strobe levels, active high, updated once stages two and three agree.
  logic as_q_reg, ws_q_reg, sa_q_reg;
  // Sequencer state and its cycle counter.
  rmc_state_t state_reg;
  logic [7:0] cyc_reg;
  // Cache-on flip-flop, suppress flag and tag clear counter.
  logic cache_on_reg, suppress_reg;
  logic [7:0] clr_reg;
  // Match samples, the third (enable) latch and captured write data.
  logic match1_reg, match2_reg, ack_en_reg;
  logic [31:0] wdata_reg;
  // Statistic counters.
  logic [31:0] hits_reg, misses_reg;
  // AHB data phase bookkeeping.
  logic dp_wr_reg;
  logic [31:0] dp_addr_reg;

  // Line index of an address.
  function automatic logic [IDX_W-1:0] line_idx(input logic [31:0] a);
    line_idx = a[IDX_W+1:2];
  endfunction : line_idx

  // Tag word that a cycle presents for compare or store.
  function automatic logic [TAG_W-1:0] tag_of(input rmc_cpu_bus_t b);
    tag_of = {b.addr[31:IDX_W+2], b.transfer_size, b.function_code};
  endfunction : tag_of

  // Decode of the cycle on the bus.
  logic [IDX_W-1:0] idx;
  logic cpu_space_cycle, io_range_select, raw_match, hit_now, tag_clear;
  logic cmd_enable, cmd_disable, cmd_flush, reg_on_wr, reg_off_wr, reg_flush_wr;
  logic as_fall, as_rise, ws_rise, refill_done;

  always_comb begin
    idx = line_idx(cpu_bus.addr); // R6 R10
    cpu_space_cycle = (cpu_bus.function_code == `RMC_CPU_SPACE_FC);
    io_range_select = ((cpu_bus.addr & IO_MASK) == IO_BASE);
    // Stored valid pair must equal the tied-high pair.
    raw_match = (tag_mem[idx] == tag_of(cpu_bus)) && (valid_mem[idx] == 2'b11); // R6 R8
    // Hit is blocked for CPU space, I/O, disabled cache and idle strobe.
    hit_now = match2_reg && !cpu_space_cycle && !io_range_select && cache_on_reg && as_q_reg; // R9
  end

  // Strobe edges as seen after filtering.
  always_comb begin
    as_fall = as_sync_reg[1] == as_sync_reg[2] && !as_sync_reg[2] && !as_q_reg;
    as_rise = as_sync_reg[1] == as_sync_reg[2] && as_sync_reg[2] && as_q_reg;
    ws_rise = ws_sync_reg[1] == ws_sync_reg[2] && ws_sync_reg[2] && ws_q_reg;
    refill_done = (cyc_reg == 8'(REFILL_CYC)) && sa_q_reg; // R21 R22
  end

  // Command decode from processor CPU space and from the register port.
  always_comb begin
    cmd_enable = 1'b0;
    cmd_disable = 1'b0;
    cmd_flush = 1'b0;
    if (as_fall && cpu_space_cycle && !cpu_bus.write) begin
      cmd_enable = (cpu_bus.addr[1:0] == `RMC_CMD_ENABLE); // R11
      cmd_disable = (cpu_bus.addr[1:0] == `RMC_CMD_DISABLE); // R11
      cmd_flush = (cpu_bus.addr[1:0] == `RMC_CMD_FLUSH); // R11
    end
    reg_on_wr = dp_wr_reg && dp_addr_reg == `RMC_OFF_CTRL && hwdata[`RMC_CTRL_ON_BIT];
    reg_off_wr = dp_wr_reg && dp_addr_reg == `RMC_OFF_CTRL && !hwdata[`RMC_CTRL_ON_BIT];
    reg_flush_wr = dp_wr_reg && dp_addr_reg == `RMC_OFF_CTRL && hwdata[`RMC_CTRL_FLUSH_BIT];
    // Enable also flushes so a session starts clean.
    tag_clear = cmd_enable || cmd_flush || reg_flush_wr || (reg_on_wr && !cache_on_reg); // R12 R13
  end

  // Pin synchronisers; each stage feeds the next.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      as_sync_reg <= 3'h7;
      ws_sync_reg <= 3'h7;
      sa_sync_reg <= 3'h7;
    end else begin
      as_sync_reg <= {as_sync_reg[1:0], cpu_bus.addr_strobe_n};
      ws_sync_reg <= {ws_sync_reg[1:0], cpu_bus.wr_strobe_n};
      sa_sync_reg <= {sa_sync_reg[1:0], sys_ack_n};
    end
  end

  // Filtered levels change when stages two and three agree.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      as_q_reg <= 1'b0;
      ws_q_reg <= 1'b0;
      sa_q_reg <= 1'b0;
    end else begin
      if (as_sync_reg[1] == as_sync_reg[2]) begin
        as_q_reg <= !as_sync_reg[2];
      end
      if (ws_sync_reg[1] == ws_sync_reg[2]) begin
        ws_q_reg <= !ws_sync_reg[2];
      end
      if (sa_sync_reg[1] == sa_sync_reg[2]) begin
        sa_q_reg <= !sa_sync_reg[2];
      end
    end
  end

  // Cache-on flip-flop: off after reset, set by enable, cleared by disable.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cache_on_reg <= `RMC_CACHE_ON_RST; // R23
    end else if (cmd_enable || reg_on_wr) begin
      cache_on_reg <= 1'b1; // R12
    end else if (cmd_disable || reg_off_wr) begin
      cache_on_reg <= 1'b0; // R12
    end
  end

  // Tag clear busy time models the array reset settling.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clr_reg <= 8'h00;
    end else if (tag_clear) begin
      clr_reg <= 8'(CLR_CYC); // R7
    end else if (clr_reg != 8'h00) begin
      clr_reg <= clr_reg - 8'h01;
    end
  end

  // Valid array: cleared as a whole on tag reset, which wins over an array write in the same cycle; set on every other array write.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        valid_mem[i] <= 2'b00;
      end
    end else if (tag_clear) begin
      for (int i = 0; i < DEPTH; i++) begin
        valid_mem[i] <= 2'b00; // R7
      end
    end else if ((state_reg == RMC_WRITE && as_rise) || (state_reg == RMC_REFILL && refill_done)) begin
      valid_mem[idx] <= 2'b11; // R20
    end
  end

  // Tag and data words: written on processor writes and on refill.
  always_ff @(posedge clk) begin
    if (state_reg == RMC_WRITE && as_rise) begin
      tag_mem[idx] <= tag_of(cpu_bus); // R20
      data_mem[idx] <= wdata_reg; // R1 R20
    end else if (state_reg == RMC_REFILL && refill_done) begin
      tag_mem[idx] <= tag_of(cpu_bus); // R3 R20
      data_mem[idx] <= sys_rdata; // R22
    end
  end

  // Write data is captured while the processor write strobe is low.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdata_reg <= 32'h0000_0000;
    end else if (ws_q_reg && !ws_rise) begin
      wdata_reg <= cpu_bus.wdata;
    end
  end

  // Two cascaded samples of the match, taken every clock while the strobe is asserted.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      match1_reg <= 1'b0;
      match2_reg <= 1'b0;
    end else if (!as_q_reg) begin
      match1_reg <= 1'b0;
      match2_reg <= 1'b0;
    end else begin
      match1_reg <= raw_match; // R14
      match2_reg <= match1_reg; // R14
    end
  end

  // Third latch: answers allowed only out of reset, cache on, no suppress.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_en_reg <= 1'b0;
    end else begin
      ack_en_reg <= cache_on_reg && !suppress_reg; // R17 R19
    end
  end

  // Suppress: from end of the miss cycle to end of the refill cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      suppress_reg <= 1'b0;
    end else if (state_reg == RMC_HOLD && as_rise && cpu_resp.miss_flag) begin
      suppress_reg <= 1'b1; // R18
    end else if (state_reg == RMC_REFILL && as_rise) begin
      suppress_reg <= 1'b0; // R18
    end
  end

  // Sequencer over processor bus cycles.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= RMC_IDLE;
      cyc_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        RMC_IDLE: begin
          cyc_reg <= 8'h00;
          if (as_fall) begin
            if (suppress_reg) begin
              state_reg <= RMC_REFILL; // R3
            end else if (cpu_space_cycle) begin
              state_reg <= RMC_CMD;
            end else if (cpu_bus.write) begin
              state_reg <= RMC_WRITE;
            end else begin
              state_reg <= RMC_LOOK; // R2
            end
          end
        end
        RMC_LOOK: begin
          cyc_reg <= cyc_reg + 8'h01;
          if (!as_q_reg) begin
            state_reg <= RMC_IDLE;
          end else if (cyc_reg == 8'(BUS_ERROR_CYC)) begin
            state_reg <= RMC_HOLD; // R4
          end
        end
        RMC_REFILL: begin
          // Step past the write point so memory data is taken once, while it still stands.
          if (cyc_reg < 8'(REFILL_CYC) || refill_done) begin
            cyc_reg <= cyc_reg + 8'h01;
          end
          if (as_rise) begin
            state_reg <= RMC_IDLE; // R22
          end
        end
        RMC_HOLD, RMC_WRITE, RMC_CMD: begin
          if (as_rise || !as_q_reg) begin
            state_reg <= RMC_IDLE;
          end
        end
        default: begin
          state_reg <= RMC_IDLE;
        end
      endcase
    end
  end

  // Answers to the processor, all from flip-flops.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_resp <= '0;
    end else begin
      // Read hit: array data drives the bus while gated hit stands.
      cpu_resp.gated_hit <= hit_now && state_reg == RMC_LOOK; // R9 R10
      cpu_resp.rdata_oe <= hit_now && state_reg == RMC_LOOK; // R10
      cpu_resp.rdata <= data_mem[idx]; // R10
      // Miss flag opens the system buffers until the refill ends.
      if (state_reg == RMC_LOOK && cyc_reg == 8'(BUS_ERROR_CYC) && ack_en_reg && !hit_now) begin
        cpu_resp.miss_flag <= !cpu_space_cycle && !io_range_select; // R16
      end else if (state_reg == RMC_REFILL && as_rise) begin
        cpu_resp.miss_flag <= 1'b0;
      end
      // Acknowledge: S2 in cached reads, commands once the tag clear count is zero.
      if (!as_q_reg || state_reg == RMC_REFILL || state_reg == RMC_WRITE) begin
        cpu_resp.cycle_ack <= 1'b0; // R19
      end else if (state_reg == RMC_CMD && clr_reg == 8'h00) begin
        cpu_resp.cycle_ack <= 1'b1; // R11 R13
      end else if (state_reg == RMC_LOOK && cyc_reg == 8'(ACK_CYC)) begin
        cpu_resp.cycle_ack <= ack_en_reg && !io_range_select; // R15 R17
      end
      // Error plus halt at S4 on a miss, gated by strobe and suppress.
      if (!as_q_reg || suppress_reg) begin
        cpu_resp.bus_error <= 1'b0; // R16 R19
        cpu_resp.halt <= 1'b0;
      end else if (state_reg == RMC_LOOK && cyc_reg == 8'(BUS_ERROR_CYC)) begin
        cpu_resp.bus_error <= ack_en_reg && !hit_now && !io_range_select; // R5 R15
        cpu_resp.halt <= ack_en_reg && !hit_now && !io_range_select; // R15
      end
    end
  end

  // Hit and miss statistics.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hits_reg <= 32'h0000_0000;
      misses_reg <= 32'h0000_0000;
    end else if (state_reg == RMC_LOOK && cyc_reg == 8'(BUS_ERROR_CYC) && ack_en_reg && !io_range_select) begin
      if (hit_now) begin
        hits_reg <= hits_reg + 32'h0000_0001;
      end else begin
        misses_reg <= misses_reg + 32'h0000_0001;
      end
    end
  end

  // AHB-Lite address phase capture; zero wait, always OKAY.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 32'h0000_0000;
    end else if (hready) begin
      dp_wr_reg <= hsel && htrans[1] && hwrite;
      dp_addr_reg <= {haddr[31:2], 2'b00};
    end
  end

  // Read data registered at the address phase for the following data phase.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case ({haddr[31:2], 2'b00})
        `RMC_OFF_CTRL: hrdata <= {31'h0, cache_on_reg};
        `RMC_OFF_STATUS: hrdata <= {29'h0, clr_reg != 8'h00, suppress_reg, cache_on_reg};
        `RMC_OFF_HITS: hrdata <= hits_reg;
        `RMC_OFF_MISSES: hrdata <= misses_reg;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // The slave never stalls and never errors.
  always_comb begin
    hreadyout = 1'b1;
    hresp = 1'b0;
  end
endmodule : rmc_cache_ctrl

/* rmc_cache_ctrl_assertions.sv */
// Concurrent checks on the pins of the retry miss cache controller.
`timescale 1ns/1ns
`include "rmc_cfg.svh"
module rmc_cache_ctrl_chk #(
  parameter logic [31:0] IO_BASE = 32'hff00_0000,
  parameter logic [31:0] IO_MASK = 32'hff00_0000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire rmc_pkg::rmc_cpu_bus_t cpu_bus,
  input wire rmc_pkg::rmc_cpu_resp_t cpu_resp,
  input wire logic hreadyout,
  input wire logic hresp
);
  import rmc_pkg::*;
  logic [3:0] hi_cnt; // Length of the current idle run of the strobe pin.
  logic as_lo; // Strobe pin asserted.
  logic in_io; // Address falls in the I/O window.
  logic any_ans; // Any answer to the processor.
  assign as_lo = !cpu_bus.addr_strobe_n;
  assign in_io = (cpu_bus.addr & IO_MASK) == IO_BASE;
  assign any_ans = cpu_resp.cycle_ack || cpu_resp.bus_error || cpu_resp.halt;
  // Count idle cycles so answers can be bounded after the strobe rises.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt <= 4'h0;
    end else if (as_lo) begin
      hi_cnt <= 4'h0;
    end else if (hi_cnt != 4'hf) begin
      hi_cnt <= hi_cnt + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_bus_error_with_halt: assert property (cpu_resp.bus_error == cpu_resp.halt)
    else $error("bus error and halt differ");
  chk_bus_error_has_miss: assert property (cpu_resp.bus_error |-> cpu_resp.miss_flag)
    else $error("bus error without miss flag");
  chk_ack_before_bus_error: assert property ($rose(cpu_resp.bus_error) |-> cpu_resp.cycle_ack && $past(cpu_resp.cycle_ack, 2))
    else $error("retry error not preceded by acknowledge");
  chk_write_quiet: assert property ((as_lo && cpu_bus.write) [*4] |-> !any_ans)
    else $error("answer during a write cycle");
  chk_space_no_hit: assert property ((as_lo && cpu_bus.function_code == `RMC_CPU_SPACE_FC) [*4]
    |-> !cpu_resp.gated_hit && !cpu_resp.bus_error)
    else $error("hit or retry in cpu space");
  chk_io_no_answer: assert property ((as_lo && in_io) [*4] |-> !cpu_resp.gated_hit && !any_ans)
    else $error("answer in io range");
  chk_hit_needs_strobe: assert property (cpu_resp.gated_hit |-> hi_cnt < 4'h7)
    else $error("hit without strobe");
  chk_idle_quiet: assert property (hi_cnt >= 4'h7 |-> !any_ans && !cpu_resp.gated_hit && !cpu_resp.rdata_oe)
    else $error("answer while bus idle");
  chk_refill_quiet: assert property ((hi_cnt >= 4'h7 && cpu_resp.miss_flag) ##1 as_lo |-> (!any_ans) [*8])
    else $error("answer during refill");
  chk_hit_drives_data: assert property ((cpu_resp.gated_hit == cpu_resp.rdata_oe) && !(cpu_resp.gated_hit && cpu_resp.bus_error))
    else $error("data enable differs from hit");
  chk_ahb_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  cover property ($rose(cpu_resp.bus_error));
  cover property ($rose(cpu_resp.gated_hit));
  cover property ((hi_cnt >= 4'h7 && cpu_resp.miss_flag) ##1 as_lo);
endmodule : rmc_cache_ctrl_chk
bind rmc_cache_ctrl rmc_cache_ctrl_chk #(.IO_BASE(IO_BASE), .IO_MASK(IO_MASK)) i_chk (.clk(clk), .resetn(resetn),
  .cpu_bus(cpu_bus), .cpu_resp(cpu_resp), .hreadyout(hreadyout), .hresp(hresp));

/* rmc_sys_mem.sv */
// System memory model that answers writes and flagged misses.
`timescale 1ns/1ns
module rmc_sys_mem (
  input wire logic clk,
  input wire logic resetn,
  input wire rmc_pkg::rmc_cpu_bus_t cpu_bus,
  input wire logic miss_flag,
  input wire logic [3:0] ack_dly,
  output logic sys_ack_n,
  output logic [31:0] sys_rdata
);
  import rmc_pkg::*;
  logic [3:0] wait_cnt; // Cycles since the strobe fell.
  logic [15:0] noise; // Changing pattern shown on released data lines.
  logic serve; // Memory drives the bus.
  // Count strobe-low cycles so the answer can be prompt or slow.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_cnt <= 4'h0;
      noise <= 16'h0;
    end else begin
      noise <= noise + 16'h1;
      if (cpu_bus.addr_strobe_n) begin
        wait_cnt <= 4'h0;
      end else if (wait_cnt != 4'hf) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
  // Buffers open to memory only on writes and flagged misses.
  assign serve = !cpu_bus.addr_strobe_n && (cpu_bus.write || miss_flag) && wait_cnt >= ack_dly;
  assign sys_ack_n = !serve;
  assign sys_rdata = serve ? (cpu_bus.addr ^ 32'hc3c3_0000) : {noise, ~noise};
endmodule : rmc_sys_mem

/* rmc_testbench.sv */
// Self-checking bench for the retry miss cache controller.
`timescale 1ns/1ns
`include "rmc_cfg.svh"
`define CHECK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import rmc_pkg::*;
  logic clk, resetn, hsel, hwrite, hreadyout, hresp, sys_ack_n;
  logic [31:0] haddr, hwdata, hrdata, sys_rdata, rd, rd_s, m0, h0;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] ack_dly; // Memory answer delay, prompt or slow.
  logic hit_s; // A hit was seen in the last processor cycle.
  rmc_cpu_bus_t cpu_bus;
  rmc_cpu_resp_t cpu_resp;
  int failures, n_compared, cycles, ack_at, bus_error_at;
  rmc_cache_ctrl i_dut (.clk(clk), .resetn(resetn), .cpu_bus(cpu_bus), .sys_ack_n(sys_ack_n), .sys_rdata(sys_rdata),
    .cpu_resp(cpu_resp), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  rmc_sys_mem i_mem (.clk(clk), .resetn(resetn), .cpu_bus(cpu_bus), .miss_flag(cpu_resp.miss_flag),
    .ack_dly(ack_dly), .sys_ack_n(sys_ack_n), .sys_rdata(sys_rdata));
  // Free-running processor clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Cut a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  // Print the counts and the verdict, then stop.
  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // Word that system memory returns for an address.
  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return a ^ 32'hc3c3_0000;
  endfunction : mem_word
  // One single-word AHB transfer; read data taken at the data-phase edge.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // One processor cycle; records when acknowledge and error first appear.
  task automatic cpu(input logic [31:0] a, input logic [2:0] fc, input logic w, input logic [31:0] d);
    ack_at = 0;
    bus_error_at = 0;
    hit_s = 1'b0;
    @(posedge clk);
    cpu_bus.addr <= a;
    cpu_bus.function_code <= fc;
    cpu_bus.write <= w;
    cpu_bus.wdata <= d;
    cpu_bus.transfer_size <= 2'h0;
    @(posedge clk);
    cpu_bus.addr_strobe_n <= 1'b0;
    cpu_bus.wr_strobe_n <= !w;
    for (int i = 1; i <= 16; i++) begin
      @(negedge clk);
      if (cpu_resp.cycle_ack === 1'b1 && ack_at == 0) ack_at = i;
      if (cpu_resp.bus_error === 1'b1 && bus_error_at == 0) bus_error_at = i;
      if (cpu_resp.gated_hit === 1'b1) hit_s = 1'b1;
      if (cpu_resp.gated_hit === 1'b1) rd_s = cpu_resp.rdata;
    end
    @(posedge clk);
    cpu_bus.addr_strobe_n <= 1'b1;
    cpu_bus.wr_strobe_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : cpu
  // Idle outputs and a disabled cache after reset.
  task automatic t_reset();
    `CHECK("resp after reset", '0, cpu_resp)
    ahb(1'b0, `RMC_OFF_STATUS, 32'h0);
    `CHECK("status after reset", 32'h0, rd)
    cpu(32'h0000_1000, 3'h5, 1'b0, 32'h0);
    `CHECK("answer while off", 0, ack_at + bus_error_at)
  endtask : t_reset
  // Processor-space command, acknowledged and reflected in the on flag.
  task automatic t_cmd(input logic [1:0] code, input logic on);
    cpu({30'h0, code}, `RMC_CPU_SPACE_FC, 1'b0, 32'h0);
    `CHECK("command ack", 1, ack_at > 0)
    ahb(1'b0, `RMC_OFF_STATUS, 32'h0);
    `CHECK("cache on flag", on, rd[`RMC_STAT_ON_BIT])
  endtask : t_cmd
  // Miss with retry, silent refill, then a hit on the refilled word.
  task automatic miss_refill(input logic [31:0] a, input logic [2:0] fc, input logic [3:0] dly);
    ack_dly <= dly;
    cpu(a, fc, 1'b0, 32'h0);
    `CHECK("miss no hit", 1'b0, hit_s)
    `CHECK("retry in time", 1, ack_at > 0 && bus_error_at > ack_at && bus_error_at <= 13)
    `CHECK("ack to error spacing", 4, bus_error_at - ack_at)
    ahb(1'b0, `RMC_OFF_STATUS, 32'h0);
    `CHECK("suppress set", 1'b1, rd[`RMC_STAT_SUPP_BIT])
    cpu(a, fc, 1'b0, 32'h0);
    `CHECK("refill silent", 0, ack_at + bus_error_at)
    ahb(1'b0, `RMC_OFF_STATUS, 32'h0);
    `CHECK("suppress clear", 1'b0, rd[`RMC_STAT_SUPP_BIT])
    cpu(a, fc, 1'b0, 32'h0);
    `CHECK("hit after refill", 1'b1, hit_s)
    `CHECK("hit data", mem_word(a), rd_s)
    `CHECK("hit ack no error", 1, ack_at == `RMC_CYC_FLOOR(`RMC_ACK_NS) + 6 && bus_error_at == 0)
  endtask : miss_refill
  // Write-through updates the line and leaves timing to memory.
  task automatic t_write();
    cpu(32'h0000_2004, 3'h5, 1'b1, 32'ha5a5_0f0f);
    `CHECK("write silent", 0, ack_at + bus_error_at)
    cpu(32'h0000_2004, 3'h5, 1'b0, 32'h0);
    `CHECK("written data", 32'ha5a5_0f0f, rd_s)
    cpu(32'hff00_0010, 3'h5, 1'b0, 32'h0);
    `CHECK("io range silent", 0, ack_at + bus_error_at + hit_s)
  endtask : t_write
  // Counters, read-only protection and an unmapped address.
  task automatic t_regs();
    ahb(1'b0, `RMC_OFF_MISSES, 32'h0);
    m0 = rd;
    ahb(1'b0, `RMC_OFF_HITS, 32'h0);
    h0 = rd;
    miss_refill(32'h0000_3008, 3'h1, 4'h1);
    ahb(1'b1, `RMC_OFF_MISSES, 32'h0);
    ahb(1'b0, `RMC_OFF_MISSES, 32'h0);
    `CHECK("miss count", m0 + 32'h1, rd)
    ahb(1'b0, `RMC_OFF_HITS, 32'h0);
    `CHECK("hit count", h0 + 32'h1, rd)
    ahb(1'b0, 32'h0000_0010, 32'h0);
    `CHECK("unmapped read", 32'h0, rd)
  endtask : t_regs
  initial begin
    resetn = 1'b0;
    cpu_bus = '0;
    cpu_bus.addr_strobe_n = 1'b1;
    cpu_bus.wr_strobe_n = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    ack_dly = 4'h1;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_cmd(`RMC_CMD_ENABLE, 1'b1);
    miss_refill(32'h0000_1000, 3'h5, 4'h1);
    miss_refill(32'h0000_1000, 3'h6, 4'h8);
    miss_refill(32'h0000_9000, 3'h6, 4'h2);
    miss_refill(32'h0000_1000, 3'h6, 4'h1);
    t_write();
    t_cmd(`RMC_CMD_FLUSH, 1'b1);
    miss_refill(32'h0000_2004, 3'h5, 4'h1);
    t_cmd(`RMC_CMD_DISABLE, 1'b0);
    cpu(32'h0000_2004, 3'h5, 1'b0, 32'h0);
    `CHECK("disabled silent", 0, ack_at + bus_error_at + hit_s)
    ahb(1'b1, `RMC_OFF_CTRL, 32'h1);
    miss_refill(32'h0000_2004, 3'h5, 4'h1);
    t_regs();
    give_verdict();
  end
endmodule : testbench
